/* rtl/usb_irq_pkg.sv */
// Constants and types shared by the USB interrupt and error-status logic
package usb_irq_pkg;

    // ========================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_IRQ_FLAG   = 10'h190;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h191;
    localparam logic [9:0] IDX_ERR_FLAG   = 10'h192;
    localparam logic [9:0] IDX_ERR_ENABLE = 10'h193;
    localparam logic [9:0] IDX_STATUS     = 10'h194;
    localparam logic [9:0] IDX_SUSPEND    = 10'h198;
    localparam int         IDX_LSB        = 2;
    localparam int         IDX_MSB        = 11;

    // ========================================
    // Main interrupt flag and enable bit positions, and the suspend control bit
    localparam int BIT_BUS_RESET  = 0;
    localparam int BIT_ERR_SUM    = 1;
    localparam int BIT_ACTIVITY   = 2;
    localparam int BIT_TOK_DONE   = 3;
    localparam int BIT_IDLE       = 4;
    localparam int BIT_STALL      = 5;
    localparam int BIT_SUSPEND    = 0;

    // ========================================
    // Error flag bit positions
    localparam int BIT_ERR_PID    = 0;
    localparam int BIT_ERR_TOKEN_CRC_FAULT   = 1;
    localparam int BIT_ERR_DATA_CRC_FAULT  = 2;
    localparam int BIT_ERR_LEN    = 3;
    localparam int BIT_ERR_BTO    = 4;
    localparam int BIT_ERR_WRT    = 5;
    localparam int BIT_ERR_OWN    = 6;
    localparam int BIT_ERR_STUFF  = 7;

    // ========================================
    // Widths, masks and reset values
    localparam int         REG_W        = 8;
    localparam int         FIFO_DEPTH   = 4;
    localparam int         PTR_W        = 2;
    localparam int         CNT_W        = 3;
    localparam logic [7:0] IRQ_IMPL     = 8'h3F;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
    localparam logic [1:0] HRESP_OKAY   = 2'h0;

    typedef logic [REG_W-1:0] byte_t;

    // Events from the serial engine, each flag a one-cycle pulse, with the token status byte alongside
    typedef struct packed {
        logic  stall;
        logic  bus_idle;
        logic  activity;
        logic  bus_reset;
        logic  bit_stuff_fault;
        logic  owner_fault;
        logic  write_conflict_fault;
        logic  turnaround_timeout_fault;
        logic  byte_length_fault;
        logic  data_crc_fault;
        logic  token_crc_fault;
        logic  identifier_check_fault;
        logic  token_done;
        byte_t token_status;
    } sie_events_t;

endpackage

/* rtl/status_fifo.sv */
// Four-entry byte queue behind the transaction status window
`timescale 1ns/1ps
module status_fifo (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   push,
    input  wire usb_irq_pkg::byte_t     push_data,
    input  wire logic                   pop,
    output logic                        full,
    output logic                        not_empty,
    output usb_irq_pkg::byte_t          head,
    output logic [usb_irq_pkg::CNT_W-1:0] count
);
    import usb_irq_pkg::*;

    // ========================================
    // Storage
    byte_t            mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic             do_pop;
    logic             do_push;

    assign do_pop    = pop && (count_r != '0);
    // A push into a full queue is taken only if the head leaves that cycle
    assign do_push   = push && (!full || do_pop);
    assign full      = (count_r == CNT_W'(FIFO_DEPTH));
    assign not_empty = (count_r != '0);
    assign head      = mem_r[rd_ptr_r];
    assign count     = count_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= push_data;
        end
    end

endmodule

/* rtl/usb_irq_error_status_fifo.sv */
// USB interrupt flags, error flags and transaction status queue with AHB-Lite access
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module usb_irq_error_status_fifo (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic [1:0]                    hresp,
    output logic [31:0]                   hrdata,
    input  wire usb_irq_pkg::sie_events_t sie_ev,
    output logic                          token_accept,
    output logic                          owner_release,
    output logic                          token_reject,
    output logic                          usb_irq
);
    import usb_irq_pkg::*;

    // ========================================
    // Register state
    byte_t      irq_flag_r;
    byte_t      irq_enable_r;
    byte_t      error_flag_r;
    byte_t      error_enable_r;
    logic       suspend_ctl_r;
    byte_t      irq_flag_nxt;
    byte_t      error_flag_nxt;
    logic       owner_release_r;
    logic       token_reject_r;

    // ========================================
    // AHB-Lite address and data phase
    logic       wr_pend_r;
    logic       rd_pend_r;
    logic [9:0] idx_r;
    logic       addr_take;

    assign addr_take = hsel && hready && (htrans == HTRANS_NSEQ);
    // Zero wait state slave: every access completes with OKAY
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r     <= '0;
        end else begin
            wr_pend_r <= addr_take && hwrite;
            rd_pend_r <= addr_take && !hwrite;
            if (addr_take) begin
                idx_r <= haddr[IDX_MSB:IDX_LSB];
            end
        end
    end

    // ========================================
    // Write decode
    byte_t wdata;
    logic  wr_irq_flag;
    logic  wr_irq_en;
    logic  wr_err_flag;
    logic  wr_err_en;
    logic  wr_susp;
    logic  flag_wr_ok;

    assign wdata       = hwdata[REG_W-1:0];
    // Flags may only be changed by software while the module is awake
    assign flag_wr_ok  = !suspend_ctl_r;
    assign wr_irq_flag = wr_pend_r && (idx_r == IDX_IRQ_FLAG) && flag_wr_ok;
    assign wr_irq_en   = wr_pend_r && (idx_r == IDX_IRQ_ENABLE);
    assign wr_err_flag = wr_pend_r && (idx_r == IDX_ERR_FLAG) && flag_wr_ok;
    assign wr_err_en   = wr_pend_r && (idx_r == IDX_ERR_ENABLE);
    assign wr_susp     = wr_pend_r && (idx_r == IDX_SUSPEND);

    // ========================================
    // Error flags
    byte_t err_set;
    byte_t err_clr;
    logic  err_summary;

    assign err_set[BIT_ERR_STUFF] = sie_ev.bit_stuff_fault;
    assign err_set[BIT_ERR_OWN]   = sie_ev.owner_fault;
    assign err_set[BIT_ERR_WRT]   = sie_ev.write_conflict_fault;
    assign err_set[BIT_ERR_BTO]   = sie_ev.turnaround_timeout_fault;
    assign err_set[BIT_ERR_LEN]   = sie_ev.byte_length_fault;
    assign err_set[BIT_ERR_DATA_CRC_FAULT] = sie_ev.data_crc_fault;
    assign err_set[BIT_ERR_TOKEN_CRC_FAULT]  = sie_ev.token_crc_fault;
    assign err_set[BIT_ERR_PID]   = sie_ev.identifier_check_fault;

    // Writing zero clears, writing one leaves the bit alone
    assign err_clr        = wr_err_flag ? ~wdata : RST_BYTE;
    // Set beats a clear landing in the same cycle
    assign error_flag_nxt = (error_flag_r & ~err_clr) | err_set;
    assign err_summary    = |(error_flag_r & error_enable_r);

    // ========================================
    // Status queue
    logic             tok_done;
    logic             tok_pop;
    logic             q_full;
    byte_t            q_head;
    logic [CNT_W-1:0] q_count;
    logic             tok_push;
    logic             tok_taken;
    byte_t            status_view;

    // Writing zero to token-done retires the shown status
    assign tok_pop      = wr_irq_flag && !wdata[BIT_TOK_DONE] && tok_done;
    assign token_accept = !q_full || tok_pop;
    // A token CRC failure means the token never completes
    assign tok_push     = sie_ev.token_done && !sie_ev.token_crc_fault;
    // Ownership goes back only when the status has a place in the queue
    assign tok_taken    = tok_push && token_accept;
    // Empty queue reads zero, never stale or unwritten storage
    assign status_view  = tok_done ? q_head : RST_BYTE;

    status_fifo u_status_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .push      (tok_push),
        .push_data (sie_ev.token_status),
        .pop       (tok_pop),
        .full      (q_full),
        .not_empty (tok_done),
        .head      (q_head),
        .count     (q_count)
    );

    // ========================================
    // Main interrupt flags
    byte_t irq_set;
    byte_t irq_clr;
    byte_t irq_view;
    byte_t irq_live;

    always_comb begin
        irq_set                = RST_BYTE;
        irq_set[BIT_STALL]     = sie_ev.stall;
        irq_set[BIT_IDLE]      = sie_ev.bus_idle;
        irq_set[BIT_ACTIVITY]  = sie_ev.activity;
        irq_set[BIT_BUS_RESET] = sie_ev.bus_reset;
    end

    // Token-done and error summary are derived, not stored here
    assign irq_clr      = wr_irq_flag ? ~wdata : RST_BYTE;
    assign irq_flag_nxt = ((irq_flag_r & ~irq_clr) | irq_set) & IRQ_IMPL;

    always_comb begin
        irq_view               = irq_flag_r;
        irq_view[BIT_TOK_DONE] = tok_done;
        irq_view[BIT_ERR_SUM]  = err_summary;
    end

    always_comb begin
        irq_live = irq_view & irq_enable_r;
        if (suspend_ctl_r) begin
            irq_live = irq_live & (RST_BYTE | (8'h01 << BIT_ACTIVITY));
        end
    end

    // ========================================
    // Register update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flag_r      <= RST_BYTE;
            irq_enable_r    <= RST_BYTE;
            error_flag_r    <= RST_BYTE;
            error_enable_r  <= RST_BYTE;
            suspend_ctl_r   <= 1'b0;
            owner_release_r <= 1'b0;
            token_reject_r  <= 1'b0;
            usb_irq         <= 1'b0;
        end else begin
            irq_flag_r      <= irq_flag_nxt;
            error_flag_r    <= error_flag_nxt;
            if (wr_irq_en) begin
                irq_enable_r <= wdata & IRQ_IMPL;
            end
            if (wr_err_en) begin
                error_enable_r <= wdata;
            end
            if (wr_susp) begin
                suspend_ctl_r <= wdata[BIT_SUSPEND];
            end
            // A dropped token keeps its descriptor, so no status is lost silently
            owner_release_r <= tok_taken;
            token_reject_r  <= sie_ev.token_done && sie_ev.token_crc_fault;
            usb_irq         <= |irq_live;
        end
    end

    assign owner_release = owner_release_r;
    assign token_reject  = token_reject_r;

    // ========================================
    // Read mux, valid through the data phase
    byte_t rd_byte;

    always_comb begin
        case (idx_r)
            IDX_IRQ_FLAG:   rd_byte = irq_view;
            IDX_IRQ_ENABLE: rd_byte = irq_enable_r;
            IDX_ERR_FLAG:   rd_byte = error_flag_r;
            IDX_ERR_ENABLE: rd_byte = error_enable_r;
            IDX_STATUS:     rd_byte = status_view;
            IDX_SUSPEND:    rd_byte = {7'h00, suspend_ctl_r};
            default:        rd_byte = RST_BYTE;
        endcase
    end

    assign hrdata = rd_pend_r ? {24'h000000, rd_byte} : 32'h00000000;

    // ========================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_enable_upper_zero: assert property (
        rd_pend_r && (idx_r == IDX_IRQ_ENABLE) |-> hrdata[7:6] == 2'h0)
        else $error("enable upper bits not zero");
    a_err_sets_now: assert property (
        sie_ev.byte_length_fault |=> error_flag_r[BIT_ERR_LEN])
        else $error("length fault not flagged next cycle");
    a_pid_sets_bit: assert property (
        sie_ev.identifier_check_fault |=> error_flag_r[BIT_ERR_PID])
        else $error("identifier fault not flagged");
    a_err_summary_gate: assert property (
        sie_ev.data_crc_fault && error_enable_r[BIT_ERR_DATA_CRC_FAULT] && !wr_err_en
        |=> irq_view[BIT_ERR_SUM])
        else $error("summary not raised by enabled error");
    a_write_one_keeps: assert property (
        wr_err_flag && wdata[BIT_ERR_BTO] && error_flag_r[BIT_ERR_BTO]
        |=> error_flag_r[BIT_ERR_BTO])
        else $error("write of one cleared a flag");
    a_first_token_shows: assert property (
        sie_ev.token_done && !sie_ev.token_crc_fault && !tok_done
        |=> tok_done && (q_head == $past(sie_ev.token_status)))
        else $error("status window not loaded on token");
    a_pop_reasserts: assert property (
        tok_pop && (q_count > CNT_W'(1)) |=> tok_done)
        else $error("token done not reasserted");
    a_queue_depth: assert property (
        q_count <= CNT_W'(FIFO_DEPTH))
        else $error("queue over depth");
    a_suspend_gate: assert property (
        suspend_ctl_r && !(irq_view[BIT_ACTIVITY] && irq_enable_r[BIT_ACTIVITY])
        |=> !usb_irq)
        else $error("interrupt leaked during suspend");
    a_owner_release: assert property (
        tok_taken |=> owner_release)
        else $error("ownership not released");

    c_queue_full: cover property (q_full);
    c_pop_with_more: cover property (tok_pop && (q_count > CNT_W'(1)));
    c_err_irq: cover property (err_summary && irq_enable_r[BIT_ERR_SUM] ##1 usb_irq);
    c_suspend_wake: cover property (suspend_ctl_r && sie_ev.activity ##2 usb_irq);
    c_token_reject: cover property (sie_ev.token_done && sie_ev.token_crc_fault ##1 token_reject);

    // ========================================
    // Queue, bus and gating checks
    // Queue counts are checked against the strobes only when a push or a pop comes alone, so a push can hide a missed pop
    a_reject_pulse: assert property (
        sie_ev.token_done && sie_ev.token_crc_fault |=> token_reject && !owner_release)
        else $error("bad token not rejected");
    a_crc_not_queued: assert property (
        sie_ev.token_done && sie_ev.token_crc_fault && !tok_pop
        |=> q_count == $past(q_count))
        else $error("rejected token entered the queue");
    a_full_refuses: assert property (
        q_full && !tok_pop |-> !token_accept)
        else $error("full queue still accepting");
    a_queue_grows: assert property (
        tok_taken && !tok_pop |=> q_count == $past(q_count) + CNT_W'(1))
        else $error("accepted token not queued");
    a_no_release_drop: assert property (
        tok_push && !token_accept |=> !owner_release)
        else $error("ownership released for a dropped token");
    a_release_pulse: assert property (
        owner_release |-> $past(tok_taken))
        else $error("ownership released with no token");
    a_pop_advances: assert property (
        tok_pop && !tok_push |=> q_count == $past(q_count) - CNT_W'(1))
        else $error("pop did not retire the head");
    a_pop_empties: assert property (
        tok_pop && !tok_push && (q_count == CNT_W'(1)) |=> !tok_done)
        else $error("token done left set on empty queue");
    a_window_head: assert property (
        tok_done && rd_pend_r && (idx_r == IDX_STATUS)
        |-> hrdata[REG_W-1:0] == q_head)
        else $error("status window not showing the head");
    // Flag writes are only checked where no event can set the same bit
    a_write_zero_clears: assert property (
        wr_err_flag && !wdata[BIT_ERR_LEN] && !sie_ev.byte_length_fault
        |=> !error_flag_r[BIT_ERR_LEN])
        else $error("write of zero left a flag set");
    a_suspend_locks: assert property (
        suspend_ctl_r && wr_pend_r && (idx_r == IDX_ERR_FLAG) && (err_set == RST_BYTE)
        |=> error_flag_r == $past(error_flag_r))
        else $error("error flags changed during suspend");
    a_activity_latched: assert property (
        sie_ev.activity |=> irq_flag_r[BIT_ACTIVITY])
        else $error("activity flag not set");
    a_summary_masked: assert property (
        error_enable_r == RST_BYTE |-> !irq_view[BIT_ERR_SUM])
        else $error("summary raised with no error enabled");
    // Request is one flop behind the gated flags
    a_irq_follows: assert property (
        !suspend_ctl_r |=> usb_irq == $past(|(irq_view & irq_enable_r)))
        else $error("interrupt request does not follow flags");
    a_idle_no_irq: assert property (
        irq_enable_r == RST_BYTE |=> !usb_irq)
        else $error("interrupt with every enable off");
    a_irq_unimpl: assert property (
        (irq_enable_r & ~IRQ_IMPL) == RST_BYTE)
        else $error("unimplemented enable bit set");

endmodule

/* verif/fw_model.sv */
// Firmware side model: AHB-Lite master that services the USB interrupt block
`timescale 1ns/1ps
module fw_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    import usb_irq_pkg::*;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
    end

    // ========================================
    // Single word transfer; no latency assumed, both phases wait on hready
    task automatic xfer(input logic [9:0] idx, input logic wr, input byte_t wd,
                        output byte_t rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, idx, 2'b00};
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata[7:0];
    endtask

    task automatic wr(input logic [9:0] idx, input byte_t wd);
        byte_t dummy;
        xfer(idx, 1'b1, wd, dummy);
    endtask

    // ========================================
    // Clearing writes zero only where a flag is to go; ones leave flags alone
    task automatic clr(input logic [9:0] idx, input byte_t mask);
        wr(idx, ~mask);
    endtask
endmodule

/* verif/test_usb_irq_error_status_fifo.sv */
// Self-checking bench for the USB interrupt, error flag and status queue block
`timescale 1ns/1ps
module test_usb_irq_error_status_fifo;
    import usb_irq_pkg::*;

    typedef struct packed {
        logic [9:0] idx;
        byte_t      wd;
        byte_t      exp;
    } row_t;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [1:0]  hresp;
    logic [31:0] hrdata;
    sie_events_t sie_ev;
    sie_events_t ev;
    logic        token_accept;
    logic        owner_release;
    logic        token_reject;
    logic        usb_irq;
    byte_t       v;
    int          error_cnt;
    int          n_compared;
    row_t        rows [6];

    usb_irq_error_status_fifo u_usb_irq_error_status_fifo (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sie_ev(sie_ev),
        .token_accept(token_accept), .owner_release(owner_release),
        .token_reject(token_reject), .usb_irq(usb_irq)
    );

    fw_model u_fw_model (
        .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
    );

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ========================================
    // Checking helpers
    task automatic check(input string what, input byte_t seen, input byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [9:0] idx, input byte_t mask, output byte_t got);
        u_fw_model.xfer(idx, 1'b0, 8'h00, got);
        got = got & mask;
    endtask

    // Level output is registered, so let a few edges pass before looking
    task automatic irqchk(input logic exp);
        repeat (3) @(posedge hclk);
        #1;
        check("usb_irq", {7'h00, usb_irq}, {7'h00, exp});
    endtask

    task automatic pulse(input sie_events_t e);
        @(posedge hclk);
        sie_ev <= e;
        @(posedge hclk);
        sie_ev <= '0;
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        conclude();
    end

    // ========================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        sie_ev = '0;
        ev = '0;
        error_cnt = 0;
        n_compared = 0;
        rows[0] = '{IDX_IRQ_ENABLE, 8'hFF, 8'h3F};
        rows[1] = '{IDX_IRQ_ENABLE, 8'h15, 8'h15};
        rows[2] = '{IDX_ERR_ENABLE, 8'hA5, 8'hA5};
        rows[3] = '{IDX_ERR_ENABLE, 8'h5A, 8'h5A};
        rows[4] = '{IDX_STATUS, 8'hFF, 8'h00};
        rows[5] = '{10'h1A0, 8'hFF, 8'h00};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            u_fw_model.wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, 8'hFF, v);
            check("table", v, rows[i].exp);
        end
        check("hresp", {6'h00, hresp}, {6'h00, HRESP_OKAY});
        $display("register table done");
        // Second reset in mid-run clears every register
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_IRQ_ENABLE, 8'hFF, v);
        check("irq_enable_reg", v, 8'h00);
        rd(IDX_ERR_ENABLE, 8'hFF, v);
        check("error_enable_reg", v, 8'h00);
        rd(IDX_ERR_FLAG, 8'hFF, v);
        check("error_flag_reg", v, 8'h00);
        check("reset irq", {7'h00, usb_irq}, 8'h00);
        $display("reset done");
        // Every fault source in turn, with no token around it
        for (int i = 0; i < 8; i++) begin
            ev = '0;
            ev[9 + i] = 1'b1;
            pulse(ev);
            rd(IDX_ERR_FLAG, 8'hFF, v);
            check("fault", v, 8'((16'h1 << (i + 1)) - 1));
        end
        rd(IDX_IRQ_FLAG, 8'h02, v);
        check("summary off", v, 8'h00);
        u_fw_model.wr(IDX_ERR_ENABLE, 8'h08);
        rd(IDX_IRQ_FLAG, 8'h02, v);
        check("summary on", v, 8'h02);
        u_fw_model.wr(IDX_IRQ_ENABLE, 8'h02);
        irqchk(1'b1);
        u_fw_model.wr(IDX_IRQ_ENABLE, 8'h00);
        irqchk(1'b0);
        rd(IDX_IRQ_FLAG, 8'h02, v);
        check("summary polled", v, 8'h02);
        u_fw_model.clr(IDX_ERR_FLAG, 8'h08);
        u_fw_model.wr(IDX_ERR_FLAG, 8'hFF);
        rd(IDX_ERR_FLAG, 8'hFF, v);
        check("error clear", v, 8'hF7);
        rd(IDX_IRQ_FLAG, 8'h02, v);
        check("summary clear", v, 8'h00);
        $display("error flags done");
        // Suspend lets only activity through
        u_fw_model.wr(IDX_ERR_ENABLE, 8'hFF);
        u_fw_model.wr(IDX_IRQ_ENABLE, 8'h06);
        irqchk(1'b1);
        u_fw_model.wr(IDX_SUSPEND, 8'h01);
        irqchk(1'b0);
        // Flag writes are locked out while suspended
        u_fw_model.clr(IDX_ERR_FLAG, 8'hFF);
        rd(IDX_ERR_FLAG, 8'hFF, v);
        check("suspend lock", v, 8'hF7);
        ev = '0;
        ev.activity = 1'b1;
        pulse(ev);
        irqchk(1'b1);
        u_fw_model.wr(IDX_SUSPEND, 8'h00);
        u_fw_model.clr(IDX_IRQ_FLAG, 8'h04);
        rd(IDX_IRQ_FLAG, 8'h04, v);
        check("activity clear", v, 8'h00);
        u_fw_model.wr(IDX_IRQ_ENABLE, 8'h00);
        $display("suspend done");
        // Five tokens back to back into a four-entry queue
        for (int i = 0; i < 5; i++) begin
            @(posedge hclk);
            ev = '0;
            ev.token_done = 1'b1;
            ev.token_status = 8'h11 + 8'(i);
            sie_ev <= ev;
            #1;
            check("accept", {7'h00, token_accept}, {7'h00, i < 4});
            check("release", {7'h00, owner_release}, {7'h00, i > 0});
        end
        @(posedge hclk);
        sie_ev <= '0;
        #1;
        check("dropped", {7'h00, owner_release}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            rd(IDX_STATUS, 8'hFF, v);
            check("window", v, 8'h11 + 8'(k));
            rd(IDX_IRQ_FLAG, 8'h08, v);
            check("token done", v, 8'h08);
            u_fw_model.clr(IDX_IRQ_FLAG, 8'h08);
        end
        rd(IDX_IRQ_FLAG, 8'h08, v);
        check("queue empty", v, 8'h00);
        $display("status queue done");
        // Token arriving with a token CRC failure is turned away
        ev = '0;
        ev.token_done = 1'b1;
        ev.token_crc_fault = 1'b1;
        ev.token_status = 8'h77;
        @(posedge hclk);
        sie_ev <= ev;
        @(posedge hclk);
        sie_ev <= '0;
        #1;
        check("reject", {7'h00, token_reject}, 8'h01);
        check("no release", {7'h00, owner_release}, 8'h00);
        rd(IDX_IRQ_FLAG, 8'h08, v);
        check("not queued", v, 8'h00);
        $display("reject done");
        conclude();
    end
endmodule
